/* design/dqc_pkg.sv */
// dqc_pkg: constants, register map and types of the dac clocking / correction front end
// assumes: one 50 MHz clock mclk, registers reached over an avalon-mm slave port
package dqc_pkg;

  // ****************************************
  // widths and clock
  // ****************************************
  localparam int MCLK_HZ = 50_000_000;
  localparam int DATA_W = 14;
  localparam int GAIN_W = 11;
  localparam int PHASE_W = 10;
  localparam int OFFSET_W = 13;
  localparam int GAIN_FRAC = 10;
  localparam int PHASE_FRAC = 12;
  localparam int ADDR_W = 8;
  localparam int PTR_W = 3;
  localparam int FIFO_DRIFT_LIMIT = 4;
  localparam logic [PTR_W-1:0] NEAR_TWO_DIST = 3'h2;
  localparam logic [PTR_W-1:0] NEAR_ONE_DIST = 3'h1;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_GAIN_I = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GAIN_Q = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PHASE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_OFFSET_I = 8'h10;
  localparam logic [ADDR_W-1:0] REG_OFFSET_Q = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PIN_SETUP = 8'h18;
  localparam logic [ADDR_W-1:0] REG_ALARM_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h20;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int PIN_ROUTE_BIT = 7;
  localparam int PIN_FOUR_WIRE_BIT = 6;
  localparam int ST_NEAR_TWO_BIT = 0;
  localparam int ST_NEAR_ONE_BIT = 1;
  localparam int ST_COLLIDE_BIT = 2;
  localparam int STATUS_W = 3;

  localparam logic [GAIN_W-1:0] GAIN_RESET = 11'h400;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 10'h000;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 13'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic {DQC_MODE_DUAL_OUT, DQC_MODE_DDR} dqc_mode_t;
  typedef enum logic {WORD_I, WORD_Q} dqc_word_t;

endpackage : dqc_pkg

/* design/dqc_qmc_path.sv */
// dqc_qmc_path: one corrected channel, gain then cross phase term then offset, saturated
// assumes: inputs stable for the cycle in which inValid is high; result one edge later
`timescale 1ns/1ps
module dqc_qmc_path (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic inValid,
  input wire logic signed [dqc_pkg::DATA_W-1:0] sampleMain,
  input wire logic signed [dqc_pkg::DATA_W-1:0] sampleCross,
  input wire logic [dqc_pkg::GAIN_W-1:0] gain,
  input wire logic signed [dqc_pkg::PHASE_W-1:0] phase,
  input wire logic signed [dqc_pkg::OFFSET_W-1:0] offset,
  output logic signed [dqc_pkg::DATA_W-1:0] outSample,
  output logic outValid
);
  import dqc_pkg::*;

  localparam int SUM_W = 20;
  localparam logic signed [SUM_W-1:0] SAT_MAX = 20'sh01FFF;
  localparam logic signed [SUM_W-1:0] SAT_MIN = -20'sh02000;

  typedef struct packed {
    logic signed [DATA_W-1:0] sample;
    logic valid;
  } dqc_qmc_state_t;

  dqc_qmc_state_t q;
  dqc_qmc_state_t d;
  logic signed [DATA_W+GAIN_W:0] gainProd;
  logic signed [DATA_W+PHASE_W-1:0] phaseProd;
  logic signed [SUM_W-1:0] sum;

  // clamp instead of wrap, so a large offset flattens the peak
  function automatic logic signed [DATA_W-1:0] saturate(input logic signed [SUM_W-1:0] v);
    if (v > SAT_MAX) begin
      return SAT_MAX[DATA_W-1:0];
    end else if (v < SAT_MIN) begin
      return SAT_MIN[DATA_W-1:0];
    end
    return v[DATA_W-1:0];
  endfunction : saturate

  always_comb begin
    gainProd = sampleMain * $signed({1'b0, gain});
    phaseProd = sampleCross * phase;
    // gain first, offset last, so lowering the gain leaves room for the offset
    sum = SUM_W'(gainProd >>> GAIN_FRAC) + SUM_W'(phaseProd >>> PHASE_FRAC)
      + SUM_W'(offset);
    d = q;
    d.valid = inValid;
    if (inValid) begin
      d.sample = saturate(sum);
    end
    if (clear) begin
      d.sample = '0;
      d.valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign outSample = q.sample;
  assign outValid = q.valid;

  a_clear_kills_valid: assert property (@(posedge mclk) disable iff (!rstn)
    clear |=> (!outValid && outSample == '0)) else $error("clear did not empty the path");

endmodule : dqc_qmc_path

/* design/dqc_front_end.sv */
// dqc_front_end: input word latching, sample clock division, fifo proximity alarms and
// quadrature correction of a dual 14-bit dac, with an avalon-mm register slave
// assumes: mclk is the conversion clock; data, marker and sync pins arrive synchronous
// to it; the fall-edge word of ddr mode is captured by pad logic and offered on dataInFall
`timescale 1ns/1ps
module dqc_front_end (
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [dqc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sample source side
  input wire logic [dqc_pkg::DATA_W-1:0] dataIn,
  input wire logic [dqc_pkg::DATA_W-1:0] dataInFall,
  input wire logic iqPhaseMarker,
  input wire logic blockSync,
  output logic ioClkOut,
  output logic ioClkOe,
  // input fifo pointers
  input wire logic [dqc_pkg::PTR_W-1:0] fifoWrPtr,
  input wire logic [dqc_pkg::PTR_W-1:0] fifoRdPtr,
  output logic alarmNearTwo,
  output logic alarmNearOne,
  output logic alarmPinOut,
  // converter side
  output logic sampleClkOut,
  output logic [dqc_pkg::DATA_W-1:0] dacI,
  output logic [dqc_pkg::DATA_W-1:0] dacQ,
  output logic dacValid
);
  import dqc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dqc_mode_t mode;
    logic [GAIN_W-1:0] gainI;
    logic [GAIN_W-1:0] gainQ;
    logic [PHASE_W-1:0] phase;
    logic [OFFSET_W-1:0] offsetI;
    logic [OFFSET_W-1:0] offsetQ;
    logic alarmRoute;
    logic fourWire;
    logic [STATUS_W-1:0] status;
    dqc_word_t wordPhase;
    logic [DATA_W-1:0] iHold;
    logic [DATA_W-1:0] pairI;
    logic [DATA_W-1:0] pairQ;
    logic pairValid;
    logic ioClk;
    logic sampleClk;
    logic ack;
    logic [31:0] rdata;
  } dqc_fe_state_t;

  dqc_fe_state_t q;
  dqc_fe_state_t d;
  logic busReq;
  logic wrTake;
  logic softSync;
  logic modeChange;
  logic syncHit;
  logic [PTR_W-1:0] distFwd;
  logic [PTR_W-1:0] distBack;
  logic nearTwo;
  logic nearOne;
  logic collide;
  logic [STATUS_W-1:0] events;
  logic [STATUS_W-1:0] clearMask;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_a);
    return a == reg_a;
  endfunction : hit

  // ****************************************
  // fifo proximity alarms
  // ****************************************
  // eight entries give four words of drift room either way
  always_comb begin
    distFwd = fifoWrPtr - fifoRdPtr;
    distBack = fifoRdPtr - fifoWrPtr;
    // pure gates from the pointers, no clock in the path
    nearTwo = (distFwd <= NEAR_TWO_DIST) || (distBack <= NEAR_TWO_DIST);
    nearOne = (distFwd <= NEAR_ONE_DIST) || (distBack <= NEAR_ONE_DIST);
    collide = (distFwd == '0);
    events = '0;
    events[ST_NEAR_TWO_BIT] = nearTwo;
    events[ST_NEAR_ONE_BIT] = nearOne;
    events[ST_COLLIDE_BIT] = collide;
  end

  assign alarmNearTwo = nearTwo;
  assign alarmNearOne = nearOne;
  // pin shared with serial data out, so it carries alarms only in three-wire use
  assign alarmPinOut = q.alarmRoute && !q.fourWire && nearTwo;

  // ****************************************
  // bus handshake
  // ****************************************
  // every access waits exactly one cycle, then completes
  assign busReq = avs_read || avs_write;
  assign avs_waitrequest = busReq && !q.ack;
  assign wrTake = avs_write && q.ack;
  assign softSync = wrTake && hit(avs_address, REG_CTRL) && avs_writedata[CTRL_SYNC_BIT];
  assign modeChange = wrTake && hit(avs_address, REG_CTRL)
    && (avs_writedata[CTRL_MODE_BIT] != q.mode);
  assign syncHit = blockSync || softSync || modeChange;
  assign clearMask = (wrTake && hit(avs_address, REG_ALARM_STATUS))
    ? avs_writedata[STATUS_W-1:0] : '0;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.pairValid = 1'b0;
    d.ack = busReq && !q.ack;
    if (avs_read && !q.ack) begin
      d.rdata = '0;
      unique case (avs_address)
        REG_CTRL: d.rdata[CTRL_MODE_BIT] = q.mode;
        REG_GAIN_I: d.rdata[GAIN_W-1:0] = q.gainI;
        REG_GAIN_Q: d.rdata[GAIN_W-1:0] = q.gainQ;
        REG_PHASE: d.rdata[PHASE_W-1:0] = q.phase;
        REG_OFFSET_I: d.rdata[OFFSET_W-1:0] = q.offsetI;
        REG_OFFSET_Q: d.rdata[OFFSET_W-1:0] = q.offsetQ;
        REG_PIN_SETUP: begin
          d.rdata[PIN_ROUTE_BIT] = q.alarmRoute;
          d.rdata[PIN_FOUR_WIRE_BIT] = q.fourWire;
        end
        REG_ALARM_STATUS: d.rdata[STATUS_W-1:0] = q.status;
        REG_STATE: d.rdata[0] = q.wordPhase;
        default: d.rdata = '0;
      endcase
    end
    if (wrTake) begin
      unique case (avs_address)
        REG_CTRL: d.mode = dqc_mode_t'(avs_writedata[CTRL_MODE_BIT]);
        REG_GAIN_I: d.gainI = avs_writedata[GAIN_W-1:0];
        REG_GAIN_Q: d.gainQ = avs_writedata[GAIN_W-1:0];
        REG_PHASE: d.phase = avs_writedata[PHASE_W-1:0];
        REG_OFFSET_I: d.offsetI = avs_writedata[OFFSET_W-1:0];
        REG_OFFSET_Q: d.offsetQ = avs_writedata[OFFSET_W-1:0];
        REG_PIN_SETUP: begin
          d.alarmRoute = avs_writedata[PIN_ROUTE_BIT];
          d.fourWire = avs_writedata[PIN_FOUR_WIRE_BIT];
        end
        default: d.mode = q.mode;
      endcase
    end
    // write one to clear; a new event in the same cycle wins
    d.status = (q.status & ~clearMask) | events;

    // word latching, no fifo on either path, so latency is fixed
    if (syncHit) begin
      d.wordPhase = WORD_I;
      d.iHold = '0;
      d.sampleClk = 1'b0;
      d.ioClk = 1'b0;
    end else if (q.mode == DQC_MODE_DUAL_OUT) begin
      d.ioClk = !q.ioClk;
      // marker forces the I slot, whether it is a pattern or one pulse
      if (iqPhaseMarker || q.wordPhase == WORD_I) begin
        d.iHold = dataIn;
        d.wordPhase = WORD_Q;
        d.sampleClk = 1'b1;
      end else begin
        d.pairI = q.iHold;
        d.pairQ = dataIn;
        d.pairValid = 1'b1;
        d.wordPhase = WORD_I;
        d.sampleClk = 1'b0;
      end
    end else begin
      // both edges' words come in the same cycle, one pair per clock
      d.pairI = dataIn;
      d.pairQ = dataInFall;
      d.pairValid = 1'b1;
      d.sampleClk = !q.sampleClk;
      d.ioClk = 1'b0;
      d.wordPhase = WORD_I;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '{mode: DQC_MODE_DUAL_OUT, gainI: GAIN_RESET, gainQ: GAIN_RESET,
        phase: PHASE_RESET, offsetI: OFFSET_RESET, offsetQ: OFFSET_RESET,
        wordPhase: WORD_I, default: '0};
    end else begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign ioClkOut = q.ioClk;
  assign ioClkOe = (q.mode == DQC_MODE_DUAL_OUT);
  assign sampleClkOut = q.sampleClk;

  // ****************************************
  // correction paths
  // ****************************************
  logic dacValidI;
  logic dacValidQ;

  dqc_qmc_path uPathI (
    .mclk(mclk),
    .rstn(rstn),
    .clear(syncHit),
    .inValid(q.pairValid),
    .sampleMain(q.pairI),
    .sampleCross(q.pairQ),
    .gain(q.gainI),
    .phase(PHASE_RESET),
    .offset(q.offsetI),
    .outSample(dacI),
    .outValid(dacValidI)
  );

  dqc_qmc_path uPathQ (
    .mclk(mclk),
    .rstn(rstn),
    .clear(syncHit),
    .inValid(q.pairValid),
    .sampleMain(q.pairQ),
    .sampleCross(q.pairI),
    .gain(q.gainQ),
    .phase(q.phase),
    .offset(q.offsetQ),
    .outSample(dacQ),
    .outValid(dacValidQ)
  );

  assign dacValid = dacValidI && dacValidQ;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_dual_q_taken;
    (q.mode == DQC_MODE_DUAL_OUT) && !syncHit && !iqPhaseMarker && q.wordPhase == WORD_Q;
  endsequence

  sequence s_pair_out;
    q.pairValid ##1 dacValid;
  endsequence

  a_div_by_two: assert property (q.pairValid ##1 (q.mode == DQC_MODE_DUAL_OUT && !syncHit
    && !$past(syncHit) && $past(q.mode) == DQC_MODE_DUAL_OUT) |-> !q.pairValid)
    else $error("dual-output mode gave two pairs back to back");
  a_marker_marks_i: assert property ((q.mode == DQC_MODE_DUAL_OUT && iqPhaseMarker
    && !syncHit) |=> (q.wordPhase == WORD_Q && q.iHold == $past(dataIn)))
    else $error("marker word not held as I");
  a_io_clock_runs: assert property ((q.mode == DQC_MODE_DUAL_OUT && !syncHit)
    |=> (ioClkOut != $past(ioClkOut)) && ioClkOe)
    else $error("data clock pin stalled");
  a_sync_clears_out: assert property (syncHit |=> !q.pairValid ##1 !dacValid)
    else $error("sync did not clear processing");
  a_fixed_latency: assert property (s_dual_q_taken ##1 (!syncHit)[*2] |-> ##0 dacValid)
    else $error("dual-output latency not two cycles");
  a_ddr_each_cycle: assert property ((q.mode == DQC_MODE_DDR && !syncHit) |=>
    (q.pairValid && q.pairI == $past(dataIn) && q.pairQ == $past(dataInFall)))
    else $error("ddr pair not taken");
  a_ddr_pair_lat: assert property ((q.mode == DQC_MODE_DDR && !syncHit) ##1 (!syncHit)
    |-> s_pair_out) else $error("ddr latency not fixed");
  a_near_nesting: assert property (nearOne |-> nearTwo)
    else $error("near-one without near-two");
  a_status_sticky: assert property (nearTwo |=> q.status[ST_NEAR_TWO_BIT])
    else $error("near-two event not recorded");
  a_alarm_pin_gate: assert property (alarmPinOut ==
    (q.alarmRoute && !q.fourWire && nearTwo))
    else $error("alarm pin does not follow its gate");
  a_bus_one_wait: assert property ((busReq && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : dqc_front_end

/* dv/dqc_src_model.sv */
// dqc_src_model: sample source model on the far side of the front end input bus
// assumes: clocked by mclk, one word per rising edge, words changed just after the edge
`timescale 1ns/1ps
module dqc_src_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic ddr,
  input wire logic [dqc_pkg::DATA_W-1:0] iWord,
  input wire logic [dqc_pkg::DATA_W-1:0] qWord,
  output logic [dqc_pkg::DATA_W-1:0] dataIn,
  output logic [dqc_pkg::DATA_W-1:0] dataInFall,
  output logic iqPhaseMarker
);
  import dqc_pkg::*;
  logic phaseQ_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phaseQ_q <= 1'b0;
      dataIn <= 14'h0000;
      dataInFall <= 14'h3FFF;
      iqPhaseMarker <= 1'b0;
    end else if (!run) begin
      // idle bus keeps moving so no stale word can pass for data
      phaseQ_q <= 1'b0;
      dataIn <= ~dataIn;
      dataInFall <= ~dataInFall;
      iqPhaseMarker <= 1'b0;
    end else if (ddr) begin
      dataIn <= iWord;
      dataInFall <= qWord;
      iqPhaseMarker <= 1'b0;
    end else begin
      phaseQ_q <= ~phaseQ_q;
      dataIn <= phaseQ_q ? qWord : iWord;
      dataInFall <= ~dataInFall;
      iqPhaseMarker <= ~phaseQ_q;
    end
  end
endmodule : dqc_src_model

/* dv/tb_dac_input_clocking_qmc.sv */
// tb_dac_input_clocking_qmc: register, clocking, correction and alarm checks of the front end
// assumes: avalon-mm slave ends each wait by dropping waitrequest; source model drives samples
`timescale 1ns/1ps
module tb_dac_input_clocking_qmc;
  import dqc_pkg::*;
  logic mclk, rstn, avsRead, avsWrite, avsWaitReq, run, ddr, blockSync;
  logic ioClkOut, ioClkOe, alarmNearTwo, alarmNearOne, alarmPinOut, sampleClkOut, dacValid;
  logic [7:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [13:0] dataIn, dataInFall, iWord, qWord, dacI, dacQ;
  logic iqPhaseMarker;
  logic [2:0] fifoWrPtr, fifoRdPtr;
  int err_count = 0;
  int cmp_count = 0;
  // I, Q, gain I, gain Q, phase, offset I, offset Q
  int cs[3][7] = '{'{1000, -2000, 1024, 1024, 0, 0, 0},
                   '{4000, 4000, 2047, 512, 511, 4095, -4096},
                   '{-8192, 8191, 1024, 1024, -512, -4096, 0}};

  dqc_front_end dut (.mclk(mclk), .rstn(rstn), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWriteData), .avs_readdata(avsReadData),
    .avs_waitrequest(avsWaitReq), .dataIn(dataIn), .dataInFall(dataInFall),
    .iqPhaseMarker(iqPhaseMarker), .blockSync(blockSync), .ioClkOut(ioClkOut),
    .ioClkOe(ioClkOe), .fifoWrPtr(fifoWrPtr), .fifoRdPtr(fifoRdPtr),
    .alarmNearTwo(alarmNearTwo), .alarmNearOne(alarmNearOne), .alarmPinOut(alarmPinOut),
    .sampleClkOut(sampleClkOut), .dacI(dacI), .dacQ(dacQ), .dacValid(dacValid));
  dqc_src_model src (.mclk(mclk), .rstn(rstn), .run(run), .ddr(ddr), .iWord(iWord),
    .qWord(qWord), .dataIn(dataIn), .dataInFall(dataInFall), .iqPhaseMarker(iqPhaseMarker));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] msk(input int v, input int w);
    return 32'(v) & ((32'h1 << w) - 32'h1);
  endfunction : msk

  // saturating gain, cross phase and offset sum of one path
  function automatic int qmc(input int x, input int g, input int c, input int p, input int o);
    int v;
    v = ((x * g) >>> 10) + ((c * p) >>> 12) + o;
    return v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
  endfunction : qmc

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    logic w;
    logic [31:0] r;
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= d;
    avsRead <= !wr;
    avsWrite <= wr;
    n = 0;
    // waitrequest read once settled, never in the step of the edge that moves it
    do begin
      @(negedge mclk);
      w = avsWaitReq;
      r = avsReadData;
      @(posedge mclk);
      n++;
    end while (w !== 1'b0 && n < 50);
    q = r;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 50) begin
      err_count++;
      close_out();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rdChk

  task automatic waitValid(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(negedge mclk);
        n++;
      end while (dacValid !== 1'b1 && n < 200);
    end
    if (n >= 200) begin
      err_count++;
      close_out();
    end
  endtask : waitValid

  task automatic clkChk(input logic ddrOn);
    logic s, o;
    int c;
    c = 0;
    @(negedge mclk);
    s = sampleClkOut;
    o = ioClkOut;
    repeat (8) begin
      @(negedge mclk);
      chk(sampleClkOut ^ s, 1);
      chk(ddrOn ? ioClkOut : ioClkOut ^ o, ddrOn ? 0 : 1);
      s = sampleClkOut;
      o = ioClkOut;
      c += (dacValid === 1'b1);
    end
    chk(c, ddrOn ? 8 : 4);
    chk(ioClkOe, !ddrOn);
  endtask : clkChk

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int d;
    rstn = 1'b0;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    run = 1'b0;
    ddr = 1'b0;
    iWord = 14'h0000;
    qWord = 14'h0000;
    blockSync = 1'b0;
    fifoWrPtr = 3'h0;
    fifoRdPtr = 3'h4;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rdChk(REG_CTRL, 0);
    rdChk(REG_GAIN_I, 32'(GAIN_RESET));
    rdChk(REG_GAIN_Q, 32'(GAIN_RESET));
    rdChk(REG_PHASE, 0);
    rdChk(REG_OFFSET_Q, 0);
    wr(8'h40, 32'hFFFF);
    rdChk(8'h40, 0);
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, 32'(m));
      ddr <= m[0];
      run <= 1'b1;
      // let the first marker realign the word phase before counting edges
      repeat (4) @(posedge mclk);
      clkChk(m[0]);
      for (int k = 0; k < 3; k++) begin
        wr(REG_GAIN_I, msk(cs[k][2], 11));
        wr(REG_GAIN_Q, msk(cs[k][3], 11));
        wr(REG_PHASE, msk(cs[k][4], 10));
        wr(REG_OFFSET_I, msk(cs[k][5], 13));
        wr(REG_OFFSET_Q, msk(cs[k][6], 13));
        rdChk(REG_OFFSET_Q, msk(cs[k][6], 13));
        iWord <= 14'(cs[k][0]);
        qWord <= 14'(cs[k][1]);
        // ddr gives a pulse every cycle, so three pulses would still show old words
        waitValid(4);
        chk(dacI, msk(qmc(cs[k][0], cs[k][2], 0, 0, cs[k][5]), 14));
        d = qmc(cs[k][1], cs[k][3], cs[k][0], cs[k][4], cs[k][6]);
        chk(dacQ, msk(d, 14));
      end
    end
    wr(REG_CTRL, 0);
    ddr <= 1'b0;
    waitValid(3);
    @(posedge mclk);
    blockSync <= 1'b1;
    @(posedge mclk);
    blockSync <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk(dacI, 0);
    chk(dacValid, 0);
    waitValid(3);
    chk(dacI, 14'h2000);
    wr(REG_CTRL, 2);
    @(posedge mclk);
    @(negedge mclk);
    chk(dacI, 0);
    for (int w = 0; w < 8; w++) begin
      for (int r = 0; r < 8; r++) begin
        @(posedge mclk);
        fifoWrPtr <= 3'(w);
        fifoRdPtr <= 3'(r);
        @(negedge mclk);
        d = (w - r) & 7;
        d = d > 4 ? 8 - d : d;
        chk(alarmNearTwo, d <= 2);
        chk(alarmNearOne, d <= 1);
      end
    end
    fifoWrPtr <= 3'h0;
    fifoRdPtr <= 3'h4;
    rdChk(REG_ALARM_STATUS, 7);
    wr(REG_ALARM_STATUS, 7);
    rdChk(REG_ALARM_STATUS, 0);
    for (int rt = 0; rt < 4; rt++) begin
      wr(REG_PIN_SETUP, 32'(rt) << 6);
      fifoWrPtr <= 3'h3;
      @(negedge mclk);
      chk(alarmPinOut, rt == 2);
      @(posedge mclk);
      fifoWrPtr <= 3'h0;
      @(negedge mclk);
      chk(alarmPinOut, 0);
    end
    close_out();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    close_out();
  end
endmodule : tb_dac_input_clocking_qmc
